//--- hw/asp_top.sv
// Asynchronous serial port: APB register slave, transmitter, receiver.
// Assumes rxd and the timer pulse are synchronous to pclk.
//
// Functional notes
// R1: Noise field rejects pulses under 31/63/127 clocks
// R2: Longer pulses always pass as valid levels
// R3: Receive stop length one or two bits
// R4: Status bit layout, reset 0000 11
// R5: Transmit interrupt also sets transmit-empty
// R6: Holding registers share one address
// R7: Frame: start, bits 0-7, parity, stops
// R8: Optional even or odd parity, both directions
// R9: Timer source gives transfer clock, bit is 16
// R10: Code 000 is 76800 baud at 16 MHz
// R11: Majority of samples at ticks 7, 8, 9
// R12: Valid write clears empty, starts shifting out
// R13: Write without prior status read is ignored
// R14: Shift start sets empty, raises transmit interrupt
// R15: Line high while disabled or nothing written
// R16: Stop bits store byte, set full, interrupt
// R17: Overrun discards new byte, keeps held byte
// R18: Receive disable acts after current frame
// R19: Parity mismatch sets flag, status-then-read clears
// R20: Baud code selects divider or timer
// R21: Zero stop bit sets framing error flag
// R22: Overrun when full; reception halts until cleared
// R23: Transmit end on finish with empty buffer
// R24: Sixteen ticks per bit, tick 0 at start
// R25: Status read recorded until next holding access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "asp_consts.svh"

module asp_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    input  wire logic        baud_timer_pulse,
    output logic             txd,
    output logic             transmit_interrupt,
    output logic             receive_interrupt
);

    asp_pkg::asp_state_s s;
    asp_pkg::asp_state_s next_s;
    logic                rx_clean;
    logic                btick;
    logic                setup;
    logic                done;
    logic                vote;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic parity(input logic [7:0] d, input logic even);
        parity = even ? ^d : ~^d;
    endfunction

    // -----------------------------------------------------------------
    // Line conditioning and transfer clock
    // -----------------------------------------------------------------
    asp_noise_filter u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (pce),
        .sel     (s.ctrl2.noise),
        .raw     (rxd),
        .clean   (rx_clean)
    );

    asp_baud_gen u_baud (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (pce),
        .baud        (s.ctrl1.baud),
        .timer_pulse (baud_timer_pulse),
        .tick        (btick)
    );

    assign setup = psel && !penable;
    assign done  = psel && penable && s.pready;
    assign vote  = majority(s.rx_samp[0], s.rx_samp[1], rx_clean);

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    always_comb begin
        next_s        = s;
        next_s.tx_irq = 1'b0;
        next_s.rx_irq = 1'b0;
        next_s.pready = setup;

        // Bus setup: decode and capture read data
        if (setup) begin
            next_s.pslverr = !(hit(paddr, `ASP_IDX_STAT) || hit(paddr, `ASP_IDX_CTRL2)
                               || hit(paddr, `ASP_IDX_HOLD));
            next_s.prdata  = '0;
            if (!pwrite && hit(paddr, `ASP_IDX_STAT)) begin
                next_s.prdata[7:2] = s.flags; // R4
            end else if (!pwrite && hit(paddr, `ASP_IDX_HOLD)) begin
                next_s.prdata[7:0] = s.rx_hold; // R6
            end
        end else begin
            next_s.pslverr = 1'b0;
        end

        // Bus access: writes and read side effects
        if (done && !s.pslverr) begin
            if (pwrite && hit(paddr, `ASP_IDX_CTRL1)) begin
                next_s.ctrl1 = pwdata[7:0];
            end
            if (pwrite && hit(paddr, `ASP_IDX_CTRL2)) begin
                next_s.ctrl2 = pwdata[2:0];
            end
            if (!pwrite && hit(paddr, `ASP_IDX_STAT)) begin
                next_s.sr_read = 1'b1; // R25
            end
            if (hit(paddr, `ASP_IDX_HOLD)) begin
                next_s.sr_read = 1'b0; // R25
                if (s.sr_read && !pwrite) begin
                    next_s.flags.pe   = 1'b0; // R19
                    next_s.flags.fe   = 1'b0; // R21
                    next_s.flags.oe   = 1'b0; // R22
                    next_s.flags.receive_full = 1'b0;
                end
                if (s.sr_read && pwrite) begin
                    next_s.tx_buf     = pwdata[7:0]; // R6 R13
                    next_s.flags.transmit_empty = 1'b0; // R12
                end
            end
        end

        // -------------------------------------------------------------
        // Transmitter
        // -------------------------------------------------------------
        case (s.tx_state)
            asp_pkg::TX_IDLE: begin
                if (s.ctrl1.tx_en && !s.flags.transmit_empty) begin
                    next_s.tx_shift   = s.tx_buf; // R12
                    next_s.tx_par     = parity(s.tx_buf, s.ctrl1.even); // R8
                    next_s.flags.transmit_empty = 1'b1; // R14 R5
                    next_s.flags.transmit_end = 1'b0; // R23
                    next_s.tx_irq     = 1'b1; // R14
                    next_s.tx_tick    = '0;
                    next_s.tx_bit     = '0;
                    next_s.tx_state   = asp_pkg::TX_START;
                end
            end
            default: begin
                if (btick && s.tx_tick != `ASP_TICK_LAST) begin
                    next_s.tx_tick = s.tx_tick + 4'h1;
                end else if (btick) begin
                    next_s.tx_tick = '0;
                    case (s.tx_state)
                        asp_pkg::TX_START: begin
                            next_s.tx_state = asp_pkg::TX_DATA; // R7
                        end
                        asp_pkg::TX_DATA: begin
                            next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
                            next_s.tx_bit   = s.tx_bit + 3'h1;
                            if (s.tx_bit == `ASP_BIT_LAST) begin
                                next_s.tx_state = s.ctrl1.par_en ? asp_pkg::TX_PAR
                                                                 : asp_pkg::TX_STOP1; // R8
                            end
                        end
                        asp_pkg::TX_PAR: begin
                            next_s.tx_state = asp_pkg::TX_STOP1;
                        end
                        asp_pkg::TX_STOP1: begin
                            next_s.tx_state = s.ctrl1.tx_stop2 ? asp_pkg::TX_STOP2
                                                               : asp_pkg::TX_IDLE;
                            if (!s.ctrl1.tx_stop2 && next_s.flags.transmit_empty) begin
                                next_s.flags.transmit_end = 1'b1; // R23
                            end
                        end
                        default: begin
                            next_s.tx_state = asp_pkg::TX_IDLE;
                            if (next_s.flags.transmit_empty) begin
                                next_s.flags.transmit_end = 1'b1; // R23
                            end
                        end
                    endcase
                end
            end
        endcase

        // Line level follows the frame position
        case (next_s.tx_state)
            asp_pkg::TX_START: next_s.txd = 1'b0; // R7
            asp_pkg::TX_DATA:  next_s.txd = next_s.tx_shift[0]; // R7
            asp_pkg::TX_PAR:   next_s.txd = next_s.tx_par; // R8
            default:           next_s.txd = 1'b1; // R15
        endcase

        // -------------------------------------------------------------
        // Receiver
        // -------------------------------------------------------------
        case (s.rx_state)
            asp_pkg::RX_IDLE: begin
                // Enable and overrun only checked between frames
                if (btick && s.ctrl1.rx_en && !s.flags.oe && !rx_clean) begin // R18 R22
                    next_s.rx_tick  = '0; // R24
                    next_s.rx_bit   = '0;
                    next_s.rx_fe    = 1'b0;
                    next_s.rx_pbad  = 1'b0;
                    next_s.rx_state = asp_pkg::RX_START;
                end
            end
            default: begin
                if (btick) begin
                    next_s.rx_tick = s.rx_tick + 4'h1; // R24
                    if (s.rx_tick == `ASP_TICK_S1) begin
                        next_s.rx_samp[0] = rx_clean; // R11
                    end
                    if (s.rx_tick == `ASP_TICK_S2) begin
                        next_s.rx_samp[1] = rx_clean; // R11
                    end
                    if (s.rx_tick == `ASP_TICK_S3) begin
                        case (s.rx_state)
                            asp_pkg::RX_START: begin
                                if (vote) begin
                                    next_s.rx_state = asp_pkg::RX_IDLE;
                                end
                            end
                            asp_pkg::RX_DATA: begin
                                next_s.rx_shift = {vote, s.rx_shift[7:1]}; // R7 R11
                            end
                            asp_pkg::RX_PAR: begin
                                next_s.rx_pbad = vote != parity(s.rx_shift, s.ctrl1.even); // R19
                            end
                            default: begin
                                next_s.rx_fe = s.rx_fe | !vote; // R21
                                if (s.rx_state == asp_pkg::RX_STOP2 || !s.ctrl2.rx_stop2) begin // R3
                                    next_s.rx_state = asp_pkg::RX_IDLE;
                                    if (next_s.flags.receive_full) begin
                                        next_s.flags.oe = 1'b1; // R22 R17
                                    end else begin
                                        next_s.rx_hold    = s.rx_shift; // R16
                                        next_s.flags.receive_full = 1'b1; // R16
                                        next_s.flags.pe   = next_s.flags.pe | s.rx_pbad; // R19
                                        next_s.flags.fe   = next_s.flags.fe | s.rx_fe | !vote; // R21
                                        next_s.rx_irq     = 1'b1; // R16
                                    end
                                end
                            end
                        endcase
                    end
                    if (s.rx_tick == `ASP_TICK_LAST) begin
                        case (s.rx_state)
                            asp_pkg::RX_START: next_s.rx_state = asp_pkg::RX_DATA;
                            asp_pkg::RX_DATA: begin
                                next_s.rx_bit = s.rx_bit + 3'h1;
                                if (s.rx_bit == `ASP_BIT_LAST) begin
                                    next_s.rx_state = s.ctrl1.par_en ? asp_pkg::RX_PAR
                                                                     : asp_pkg::RX_STOP1; // R8
                                end
                            end
                            asp_pkg::RX_PAR:   next_s.rx_state = asp_pkg::RX_STOP1;
                            asp_pkg::RX_STOP1: next_s.rx_state = asp_pkg::RX_STOP2; // R3
                            default:           next_s.rx_state = asp_pkg::RX_IDLE;
                        endcase
                    end
                end
            end
        endcase
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s         <= '0;
            s.ctrl1   <= `ASP_CTRL1_RST;
            s.ctrl2   <= `ASP_CTRL2_RST;
            s.rx_hold <= `ASP_HOLD_RST;
            s.flags   <= `ASP_FLAGS_RST; // R4
            s.txd     <= 1'b1; // R15
        end else if (pce) begin
            s <= next_s;
        end
    end

    assign prdata             = s.prdata;
    assign pready             = s.pready;
    assign pslverr            = s.pslverr;
    assign txd                = s.txd;
    assign transmit_interrupt = s.tx_irq;
    assign receive_interrupt  = s.rx_irq;

endmodule
`default_nettype wire

//--- hw/asp_consts.svh
// Constants for the asynchronous serial port: offsets, resets, counts.
// Included by the top, noise filter and baud generator files of the serial port and by the bench.
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// ---------------------------------------------------------------------
// Register indices; byte address is four times the index
// ---------------------------------------------------------------------
`define ASP_IDX_STAT    14'h0025
`define ASP_IDX_CTRL1   14'h0025
`define ASP_IDX_CTRL2   14'h0026
`define ASP_IDX_HOLD    14'h0f9b

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define ASP_CTRL1_RST   8'h00
`define ASP_CTRL2_RST   3'h0
`define ASP_HOLD_RST    8'h00
`define ASP_FLAGS_RST   6'h03

// ---------------------------------------------------------------------
// Transfer clock divisors and selects
// ---------------------------------------------------------------------
`define ASP_DIV_0       9'h00d
`define ASP_DIV_1       9'h01a
`define ASP_DIV_2       9'h034
`define ASP_DIV_3       9'h068
`define ASP_DIV_4       9'h0d0
`define ASP_DIV_5       9'h1a0
`define ASP_DIV_7       9'h060
`define ASP_BRG_TIMER   3'h6

// ---------------------------------------------------------------------
// Noise rejection, in system clock periods
// ---------------------------------------------------------------------
`define ASP_NF_OFF      2'h0
`define ASP_NF_T1       7'h1f
`define ASP_NF_T2       7'h3f
`define ASP_NF_T3       7'h7f

// ---------------------------------------------------------------------
// Ticks within one bit, receive sample ticks, and last data bit index
// ---------------------------------------------------------------------
`define ASP_TICK_LAST   4'hf
`define ASP_TICK_S1     4'h7
`define ASP_TICK_S2     4'h8
`define ASP_TICK_S3     4'h9
`define ASP_BIT_LAST    3'h7

`endif

//--- hw/asp_pkg.sv
// Types shared by the asynchronous serial port modules.
// Needs no other file.
package asp_pkg;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
    } asp_tx_e;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2
    } asp_rx_e;

    typedef struct packed {
        logic       tx_en;
        logic       rx_en;
        logic       tx_stop2;
        logic       even;
        logic       par_en;
        logic [2:0] baud;
    } asp_ctrl1_s;

    typedef struct packed {
        logic [1:0] noise;
        logic       rx_stop2;
    } asp_ctrl2_s;

    typedef struct packed {
        logic pe;
        logic fe;
        logic oe;
        logic receive_full;
        logic transmit_end;
        logic transmit_empty;
    } asp_flags_s;

    typedef struct packed {
        asp_ctrl1_s  ctrl1;
        asp_ctrl2_s  ctrl2;
        asp_flags_s  flags;
        logic        sr_read;
        logic [7:0]  rx_hold;
        logic [7:0]  tx_buf;
        asp_tx_e     tx_state;
        logic [7:0]  tx_shift;
        logic        tx_par;
        logic [3:0]  tx_tick;
        logic [2:0]  tx_bit;
        logic        txd;
        logic        tx_irq;
        asp_rx_e     rx_state;
        logic [7:0]  rx_shift;
        logic [3:0]  rx_tick;
        logic [2:0]  rx_bit;
        logic [1:0]  rx_samp;
        logic        rx_fe;
        logic        rx_pbad;
        logic        rx_irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } asp_state_s;

    typedef struct packed {
        logic       clean;
        logic [6:0] cnt;
    } asp_filt_s;

    typedef struct packed {
        logic [8:0] cnt;
        logic       tick;
    } asp_baud_s;

endpackage

//--- hw/asp_noise_filter.sv
// Receive line noise rejection for the serial port.
// Input is synchronous to pclk; output is a registered clean level.
`timescale 1ns/1ns
`default_nettype none
`include "asp_consts.svh"

module asp_noise_filter (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic [1:0] sel,
    input  wire logic       raw,
    output logic            clean
);

    asp_pkg::asp_filt_s s;
    asp_pkg::asp_filt_s next_s;

    function automatic logic [6:0] thresh(input logic [1:0] code);
        case (code)
            2'h1:    thresh = `ASP_NF_T1;
            2'h2:    thresh = `ASP_NF_T2;
            default: thresh = `ASP_NF_T3;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // Level must stand for the threshold before it is passed
    // -----------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (sel == `ASP_NF_OFF) begin
            next_s.clean = raw; // R1
            next_s.cnt   = '0;
        end else if (raw == s.clean) begin
            next_s.cnt = '0;
        end else if (s.cnt + 7'h01 >= thresh(sel)) begin
            next_s.clean = raw; // R1 R2
            next_s.cnt   = '0;
        end else begin
            next_s.cnt = s.cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.clean <= 1'b1;
            s.cnt   <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign clean = s.clean;

endmodule
`default_nettype wire

//--- hw/asp_baud_gen.sv
// Transfer clock tick generator: fixed divisors or the timer pulse.
// Timer pulse is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ns
`default_nettype none
`include "asp_consts.svh"

module asp_baud_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic [2:0] baud,
    input  wire logic       timer_pulse,
    output logic            tick
);

    asp_pkg::asp_baud_s s;
    asp_pkg::asp_baud_s next_s;

    function automatic logic [8:0] divisor(input logic [2:0] code);
        case (code)
            3'h0:    divisor = `ASP_DIV_0;
            3'h1:    divisor = `ASP_DIV_1;
            3'h2:    divisor = `ASP_DIV_2;
            3'h3:    divisor = `ASP_DIV_3;
            3'h4:    divisor = `ASP_DIV_4;
            3'h5:    divisor = `ASP_DIV_5;
            default: divisor = `ASP_DIV_7;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // One tick per transfer clock period
    // -----------------------------------------------------------------
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (baud == `ASP_BRG_TIMER) begin
            next_s.tick = timer_pulse; // R9
            next_s.cnt  = '0;
        end else if (s.cnt + 9'h001 >= divisor(baud)) begin
            next_s.tick = 1'b1; // R10 R20
            next_s.cnt  = '0;
        end else begin
            next_s.cnt = s.cnt + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule
`default_nettype wire

//--- tb/asp_top_props.sv
// Checker on the serial port top ports.
// Bound to asp_top from the bench top file; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module asp_top_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd,
    input wire logic        transmit_interrupt,
    input wire logic        receive_interrupt
);
    logic setup, hw, sr_seen, wrote;
    assign setup = pce && psel && !penable;
    assign hw = setup && pwrite && paddr == 16'h3e6c;
    // Status read remembered until a holding access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_seen <= 1'b0;
            wrote <= 1'b0;
        end else if (setup && paddr == 16'h3e6c) begin
            sr_seen <= 1'b0;
            wrote <= wrote | pwrite;
        end else if (setup && !pwrite && paddr == 16'h0094) begin
            sr_seen <= 1'b1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_a: assert property (setup |=> pready)
        else $error("no ready after setup");
    slverr_a: assert property (setup && !(paddr inside {16'h0094, 16'h0098, 16'h3e6c})
        |=> pslverr) else $error("unmapped access not refused");
    stat_bits_a: assert property (setup && !pwrite && paddr == 16'h0094
        |=> prdata[31:8] == 24'h0 && prdata[1:0] == 2'h0) else $error("status pad bits set");
    line_idle_a: assert property (!wrote |-> txd)
        else $error("line left idle before first write");
    start_irq_a: assert property (transmit_interrupt |-> !txd)
        else $error("transmit pulse without start bit");
    tx_pulse_a: assert property (transmit_interrupt |=> !transmit_interrupt)
        else $error("transmit pulse too long");
    rx_pulse_a: assert property (receive_interrupt |=> !receive_interrupt)
        else $error("receive pulse too long");
    start_len_a: assert property (transmit_interrupt |-> (!txd) [*8])
        else $error("start bit too short");
    refused_a: assert property (hw && !sr_seen |-> ##2 (!transmit_interrupt) [*2])
        else $error("unread write started transmission");
    cover property (transmit_interrupt);
    cover property (receive_interrupt);
    cover property (setup ##1 pslverr);
endmodule
`default_nettype wire

//--- tb/asp_peer.sv
// Remote serial peer: drives the receive line, decodes the transmit line.
// Even parity, one stop bit, BIT clocks per bit.
`timescale 1ns/1ns
`default_nettype none
module asp_peer #(parameter int BIT = 208) (
    input  wire logic pclk,
    input  wire logic txd,
    output var  logic rxd
);
    logic [9:0] sh;
    int         frames = 0;
    initial rxd = 1'b1;
    task send(input logic [7:0] d, input logic bp, input logic bs);
        logic [10:0] f;
        f = {~bs, ^d ^ bp, d, 1'b0};
        @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask
    // Mid-bit sampling of data, parity and stop
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge pclk);
            sh[i] = txd;
        end
        repeat (BIT) @(posedge pclk);
        frames++;
    end
endmodule
`default_nettype wire

//--- tb/async_serial_port_bench.sv
// Bench for the serial port: APB master tasks, peer on the line.
// Assumes design, checker and peer files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "asp_consts.svh"
module async_serial_port_bench;
    localparam logic [15:0] a_stat = {`ASP_IDX_STAT, 2'b00};
    localparam logic [15:0] a_ctl2 = {`ASP_IDX_CTRL2, 2'b00};
    localparam logic [15:0] a_hold = {`ASP_IDX_HOLD, 2'b00};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, rxd, txd, tx_irq, rx_irq;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #5 pclk = ~pclk;
    asp_top asp_top_inst (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .baud_timer_pulse(1'b0), .txd(txd), .transmit_interrupt(tx_irq),
        .receive_interrupt(rx_irq));
    asp_peer asp_peer_inst (.pclk(pclk), .txd(txd), .rxd(rxd));
    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask
    task rc(input logic [15:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, {24'h0, e});
    endtask
    task results;
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task t_reset;
        logic [31:0] r;
        rc(a_stat, 8'h0c);
        rc(a_hold, 8'h00);
        rc(a_ctl2, 8'h00);
        apb(1'b0, 16'h0100, 32'h0, r);
        chk({31'h0, txd}, 32'h1);
        $display("done reset");
    endtask
    task t_tx;
        wr(a_stat, 8'h98);
        wr(a_hold, 8'h5a);
        rc(a_stat, 8'h0c);
        wr(a_hold, 8'ha7);
        wait (asp_peer_inst.frames == 1);
        chk({22'h0, asp_peer_inst.sh}, {24'h3, 8'ha7});
        rc(a_stat, 8'h0c);
        $display("done tx");
    endtask
    task t_rx;
        wr(a_ctl2, 8'h02);
        wr(a_stat, 8'hd8);
        asp_peer_inst.send(8'h3c, 1'b0, 1'b0);
        rc(a_stat, 8'h1c);
        rc(a_hold, 8'h3c);
        rc(a_stat, 8'h0c);
        $display("done rx");
    endtask
    task t_err;
        asp_peer_inst.send(8'h81, 1'b1, 1'b1);
        rc(a_stat, 8'hdc);
        rc(a_hold, 8'h81);
        rc(a_stat, 8'h0c);
        $display("done errors");
    endtask
    task t_ovr;
        wr(a_ctl2, 8'h03);
        asp_peer_inst.send(8'h11, 1'b0, 1'b0);
        asp_peer_inst.send(8'h22, 1'b0, 1'b0);
        rc(a_stat, 8'h3c);
        rc(a_hold, 8'h11);
        rc(a_stat, 8'h0c);
        $display("done overrun");
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        t_ovr();
        results();
    end
endmodule
bind asp_top asp_top_props asp_top_props_inst (.pclk(pclk), .presetn(presetn),
    .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .transmit_interrupt(transmit_interrupt), .receive_interrupt(receive_interrupt));
`default_nettype wire
